//--- gio_cfg.svh
// offsets, field positions, reset values and timing for the grouped i/o port
`ifndef GIO_CFG_SVH
`define GIO_CFG_SVH
`define GIO_CTRL_OFS     8'h00
`define GIO_OUT_OFS      8'h04
`define GIO_IN_OFS       8'h08
`define GIO_ERR_OFS      8'h0C
`define GIO_STAT_OFS     8'h10
`define GIO_CTRL_DIR_LSB 0
`define GIO_CTRL_FILT    4
`define GIO_STAT_RUN     0
`define GIO_STAT_LOADED  1
`define GIO_DIR_RST      4'h0
`define GIO_FILT_RST     1'h1
`define GIO_RESP_OKAY    2'h0
`define GIO_RESP_SLVERR  2'h2
`define GIO_CLK_NS       5
`define GIO_FILT_LONG_NS 8000000
`define GIO_FILT_SHRT_NS 200000
`define GIO_CNT_W        21
`endif

//--- gio_pkg.sv
// types of the grouped i/o port
package gio_pkg;
  typedef enum logic [0:0] {
    GIO_BOOT = 1'b0,
    GIO_RUN  = 1'b1
  } gio_fsm_t;

  typedef struct packed {
    gio_fsm_t              fsm;
    logic [3:0]            dir;
    logic                  filt;
    logic                  loaded;
    logic [15:0]           out_lvl;
    logic [15:0]           filt_in;
    logic [15:0][20:0]     cnt;
    logic [15:0]           err;
    logic [15:0]           io_out;
    logic [15:0]           io_oe;
    logic                  nvm_wr;
    logic                  aw_rdy;
    logic                  aw_got;
    logic [7:0]            aw_addr;
    logic                  w_rdy;
    logic                  w_got;
    logic [31:0]           wdata;
    logic [3:0]            wstrb;
    logic                  bvalid;
    logic [1:0]            bresp;
    logic                  ar_rdy;
    logic                  rvalid;
    logic [31:0]           rdata;
    logic [1:0]            rresp;
  } gio_state_t;
endpackage

//--- gio_port.sv
// grouped-direction 16 channel digital port with axi4-lite registers
// Notes on behaviour
// - one direction bit per four-channel group
// - filter enabled: 8 ms input delay
// - filter disabled: 0.2 ms input delay
// - sixteen output error flags, one per channel
// - error flags always set in pairs
// - fault on channel 0/1 sets bits 1:0
// - flagged output goes high impedance
// - no stored configuration: all channels inputs
// - configuration applied before normal operation starts
// - configuration saved to nvm, reloaded at power-up
//
// Chosen here: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none
`include "gio_cfg.svh"
module gio_port
  import gio_pkg::*;
#(
  parameter int unsigned FILT_LONG_CYC = `GIO_FILT_LONG_NS / `GIO_CLK_NS,
  parameter int unsigned FILT_SHRT_CYC = `GIO_FILT_SHRT_NS / `GIO_CLK_NS
) (
  input  wire logic        CLK,          // 200 mhz clock
  input  wire logic        RESETN,       // sync reset, low active
  input  wire logic [7:0]  AXI_AWADDR,   // write address
  input  wire logic        AXI_AWVALID,  // write address valid
  output logic             AXI_AWREADY,  // write address ready
  input  wire logic [31:0] AXI_WDATA,    // write data
  input  wire logic [3:0]  AXI_WSTRB,    // write byte strobes
  input  wire logic        AXI_WVALID,   // write data valid
  output logic             AXI_WREADY,   // write data ready
  output logic [1:0]       AXI_BRESP,    // write response
  output logic             AXI_BVALID,   // write response valid
  input  wire logic        AXI_BREADY,   // write response ready
  input  wire logic [7:0]  AXI_ARADDR,   // read address
  input  wire logic        AXI_ARVALID,  // read address valid
  output logic             AXI_ARREADY,  // read address ready
  output logic [31:0]      AXI_RDATA,    // read data
  output logic [1:0]       AXI_RRESP,    // read response
  output logic             AXI_RVALID,   // read data valid
  input  wire logic        AXI_RREADY,   // read data ready
  input  wire logic [15:0] IO_IN,        // pin levels
  output logic [15:0]      IO_OUT,       // pin drive levels
  output logic [15:0]      IO_OE,        // pin drive enables
  input  wire logic [15:0] FAULT,        // driver overcurrent per channel
  input  wire logic        NVM_VALID,    // nvm holds a configuration
  input  wire logic [4:0]  NVM_CFG,      // stored {filter, dir[3:0]}
  output logic             NVM_WR,       // one-cycle store pulse
  output logic [4:0]       NVM_WDATA     // {filter, dir[3:0]} to store
);

  gio_state_t st;
  gio_state_t next_st;
  logic [20:0] lim;

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [31:0] gio_bmask(input logic [3:0] strb);
    logic [31:0] m;
    m = 32'h0000_0000;
    for (int b = 0; b < 4; b++) begin
      m[b*8 +: 8] = {8{strb[b]}};
    end
    return m;
  endfunction

  function automatic logic [15:0] gio_grp2ch(input logic [3:0] g);
    logic [15:0] c;
    c = 16'h0000;
    for (int i = 0; i < 16; i++) begin
      c[i] = g[i/4];
    end
    return c;
  endfunction

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    logic [31:0] m;
    m = 32'h0000_0000;
    next_st = st;
    next_st.nvm_wr = 1'b0;
    case (st.fsm)
      GIO_BOOT: begin
        if (NVM_VALID) begin
          {next_st.filt, next_st.dir} = NVM_CFG;
          next_st.loaded = 1'b1;
        end else begin
          next_st.dir  = `GIO_DIR_RST;
          next_st.filt = `GIO_FILT_RST;
        end
        next_st.fsm = GIO_RUN;
      end
      GIO_RUN: begin
        next_st.fsm = GIO_RUN;
      end
      default: begin
        next_st.fsm = GIO_BOOT;
      end
    endcase

    // input filters
    lim = st.filt ? FILT_LONG_CYC[20:0] : FILT_SHRT_CYC[20:0];
    for (int i = 0; i < 16; i++) begin
      if (IO_IN[i] == st.filt_in[i]) begin
        next_st.cnt[i] = 21'h00_0000;
      end else if (st.cnt[i] == lim - 21'h00_0001) begin
        next_st.filt_in[i] = IO_IN[i];
        next_st.cnt[i]     = 21'h00_0000;
      end else begin
        next_st.cnt[i] = st.cnt[i] + 21'h00_0001;
      end
    end

    // write channel
    if (st.aw_rdy && AXI_AWVALID) begin
      next_st.aw_got  = 1'b1;
      next_st.aw_addr = AXI_AWADDR;
    end
    if (st.w_rdy && AXI_WVALID) begin
      next_st.w_got = 1'b1;
      next_st.wdata = AXI_WDATA;
      next_st.wstrb = AXI_WSTRB;
    end
    if (st.bvalid && AXI_BREADY) begin
      next_st.bvalid = 1'b0;
    end
    if (next_st.aw_got && next_st.w_got && !st.bvalid) begin
      m = gio_bmask(next_st.wstrb);
      next_st.aw_got = 1'b0;
      next_st.w_got  = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp  = `GIO_RESP_OKAY;
      case ({next_st.aw_addr[7:2], 2'b00})
        `GIO_CTRL_OFS: begin
          if (next_st.wstrb[0]) begin
            next_st.dir    = next_st.wdata[`GIO_CTRL_DIR_LSB +: 4];
            next_st.filt   = next_st.wdata[`GIO_CTRL_FILT];
            next_st.nvm_wr = 1'b1;
          end
        end
        `GIO_OUT_OFS: begin
          next_st.out_lvl = (st.out_lvl & ~m[15:0]) | (next_st.wdata[15:0] & m[15:0]);
        end
        `GIO_ERR_OFS: begin
          next_st.err = st.err & ~(next_st.wdata[15:0] & m[15:0]);
        end
        `GIO_IN_OFS, `GIO_STAT_OFS: begin
          next_st.bresp = `GIO_RESP_OKAY;
        end
        default: begin
          next_st.bresp = `GIO_RESP_SLVERR;
        end
      endcase
    end
    next_st.aw_rdy = !next_st.aw_got && !next_st.bvalid;
    next_st.w_rdy  = !next_st.w_got && !next_st.bvalid;

    // error flags, set after clear so a new fault wins
    for (int p = 0; p < 8; p++) begin
      if (FAULT[2*p] || FAULT[2*p+1]) begin
        next_st.err[2*p +: 2] = 2'b11;
      end
    end

    // read channel
    if (st.rvalid && AXI_RREADY) begin
      next_st.rvalid = 1'b0;
    end
    if (st.ar_rdy && AXI_ARVALID) begin
      next_st.rvalid = 1'b1;
      next_st.rresp  = `GIO_RESP_OKAY;
      next_st.rdata  = 32'h0000_0000;
      case ({AXI_ARADDR[7:2], 2'b00})
        `GIO_CTRL_OFS: next_st.rdata[4:0]  = {st.filt, st.dir};
        `GIO_OUT_OFS:  next_st.rdata[15:0] = st.out_lvl;
        `GIO_IN_OFS:   next_st.rdata[15:0] = st.filt_in;
        `GIO_ERR_OFS:  next_st.rdata[15:0] = st.err;
        `GIO_STAT_OFS: next_st.rdata[1:0]  = {st.loaded, st.fsm == GIO_RUN};
        default:       next_st.rresp       = `GIO_RESP_SLVERR;
      endcase
    end
    next_st.ar_rdy = !next_st.rvalid;

    // pin drivers: output groups only, running, no error flag
    next_st.io_oe = gio_grp2ch(next_st.dir) & ~next_st.err
                    & {16{next_st.fsm == GIO_RUN}};
    next_st.io_out = next_st.out_lvl & next_st.io_oe;
  end

  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      st      <= '0;
      st.filt <= `GIO_FILT_RST;
    end else begin
      st <= next_st;
    end
  end

  assign AXI_AWREADY = st.aw_rdy;
  assign AXI_WREADY  = st.w_rdy;
  assign AXI_BVALID  = st.bvalid;
  assign AXI_BRESP   = st.bresp;
  assign AXI_ARREADY = st.ar_rdy;
  assign AXI_RVALID  = st.rvalid;
  assign AXI_RDATA   = st.rdata;
  assign AXI_RRESP   = st.rresp;
  assign IO_OUT      = st.io_out;
  assign IO_OE       = st.io_oe;
  assign NVM_WR      = st.nvm_wr;
  assign NVM_WDATA   = {st.filt, st.dir};

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESETN);

  sequence boot_s;
    st.fsm == GIO_BOOT ##1 st.fsm == GIO_RUN;
  endsequence

  grp_drive_a: assert property (IO_OE == (IO_OE & gio_grp2ch(st.dir)))
    else $error("input group drives a pin");
  filt_long_a: assert property ($changed(st.filt_in[0]) && $past(st.filt)
    |-> $past(st.cnt[0]) == FILT_LONG_CYC[20:0] - 21'h00_0001)
    else $error("long filter delay wrong");
  filt_shrt_a: assert property ($changed(st.filt_in[0]) && !$past(st.filt)
    |-> $past(st.cnt[0]) == FILT_SHRT_CYC[20:0] - 21'h00_0001)
    else $error("short filter delay wrong");
  err_pair_a: assert property (st.err[0] == st.err[1] && st.err[14] == st.err[15])
    else $error("error flags not paired");
  err_set_a: assert property ((FAULT[0] || FAULT[1]) |=> st.err[1:0] == 2'b11)
    else $error("fault on pair 0 not flagged");
  err_hiz_a: assert property (((IO_OE | IO_OUT) & st.err) == 16'h0000)
    else $error("flagged output still driven");
  dflt_in_a: assert property ((st.fsm == GIO_BOOT && !NVM_VALID)
    |=> st.dir == 4'h0 && IO_OE == 16'h0000)
    else $error("default is not all inputs");
  boot_off_a: assert property (boot_s |-> $past(IO_OE) == 16'h0000)
    else $error("pins driven before configuration");
  nvm_load_a: assert property ((st.fsm == GIO_BOOT && NVM_VALID)
    |=> NVM_WDATA == $past(NVM_CFG) && st.loaded)
    else $error("stored configuration not reloaded");
  nvm_wr_a: assert property (NVM_WR |-> $rose(AXI_BVALID) && AXI_BRESP == 2'h0)
    else $error("store pulse without control write");

endmodule
`default_nettype wire

//--- gio_field.sv
// field wiring and nvm model beside the grouped i/o port
`timescale 1ns/10ps
`default_nettype none
module gio_field (
  input  wire logic        clk,   // clock
  input  wire logic [15:0] ext,   // levels of external sources
  input  wire logic [15:0] oe,    // drive enables of the port
  input  wire logic [15:0] out,   // drive levels of the port
  input  wire logic        wr,    // store pulse
  input  wire logic [4:0]  wdata, // config to store
  output logic [15:0]      pin,   // resolved wire levels
  output var logic         valid, // a config is held
  output var logic [4:0]   cfg    // held config
);
  // ****
  // wires and storage
  // ****
  always_comb pin = (oe & out) | (~oe & ext);
  initial begin
    valid = 1'b0;
    cfg   = 5'h00;
    forever begin
      @(posedge clk);
      if (wr) begin
        valid <= 1'b1;
        cfg   <= wdata;
      end
    end
  end
endmodule
`default_nettype wire

//--- tb.sv
// self-checking bench of the grouped i/o port
`timescale 1ns/10ps
`default_nettype none
`include "gio_cfg.svh"
module tb;
  import gio_pkg::*;
  typedef struct {
    logic [31:0] ctrl;
    logic [31:0] out;
    logic [15:0] oe;
  } gio_row_t;
  // ****
  // signals
  // ****
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        awvalid = 1'b0;
  logic        wvalid = 1'b0;
  logic        arvalid = 1'b0;
  logic [7:0]  awaddr = 8'h00;
  logic [7:0]  araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic [15:0] ext = 16'h0000;
  logic [15:0] fault = 16'h0000;
  logic [3:0]  wstrb = 4'hF;
  wire logic        awready, wready, bvalid, arready, rvalid, nvm_wr, nvm_ok;
  wire logic [1:0]  bresp, rresp;
  wire logic [31:0] rdata;
  wire logic [15:0] io_out, io_oe, pin;
  wire logic [4:0]  nvm_cfg, nvm_wd;
  int          mismatches = 0;
  int          samples_checked = 0;
  gio_row_t    rows [5] = '{
    '{32'h0000_0001, 32'h0000_FFFF, 16'h000F},
    '{32'h0000_000A, 32'h0000_5A5A, 16'hF0F0},
    '{32'h0000_0014, 32'h0000_1234, 16'h0F00},
    '{32'h0000_000F, 32'h0000_A5C3, 16'hFFFF},
    '{32'h0000_0010, 32'h0000_FFFF, 16'h0000}};
  gio_port #(.FILT_LONG_CYC(20), .FILT_SHRT_CYC(4)) gio_port_inst (
    .CLK(clk), .RESETN(rst_n), .AXI_AWADDR(awaddr), .AXI_AWVALID(awvalid),
    .AXI_AWREADY(awready), .AXI_WDATA(wdata), .AXI_WSTRB(wstrb),
    .AXI_WVALID(wvalid), .AXI_WREADY(wready), .AXI_BRESP(bresp),
    .AXI_BVALID(bvalid), .AXI_BREADY(1'b1), .AXI_ARADDR(araddr),
    .AXI_ARVALID(arvalid), .AXI_ARREADY(arready), .AXI_RDATA(rdata),
    .AXI_RRESP(rresp), .AXI_RVALID(rvalid), .AXI_RREADY(1'b1),
    .IO_IN(pin), .IO_OUT(io_out), .IO_OE(io_oe), .FAULT(fault),
    .NVM_VALID(nvm_ok), .NVM_CFG(nvm_cfg), .NVM_WR(nvm_wr), .NVM_WDATA(nvm_wd));
  gio_field gio_field_inst (
    .clk(clk), .ext(ext), .oe(io_oe), .out(io_out), .wr(nvm_wr),
    .wdata(nvm_wd), .pin(pin), .valid(nvm_ok), .cfg(nvm_cfg));
  // ****
  // tasks
  // ****
  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic stuck();
    mismatches++;
    complete_run();
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic do_reset();
    rst_n <= 1'b0;
    repeat (4) @(posedge clk);
    cmp(io_oe, 32'h0000_0000);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    for (int n = 0; n < 40; n++) begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) begin
        cmp(bresp, `GIO_RESP_OKAY);
        return;
      end
    end
    stuck();
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e,
                    input logic [1:0] er = `GIO_RESP_OKAY);
    araddr  <= a;
    arvalid <= 1'b1;
    for (int n = 0; n < 40; n++) begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) begin
        cmp(rdata, e);
        cmp(rresp, er);
        return;
      end
    end
    stuck();
  endtask
  // ****
  // sequence
  // ****
  always #2.5 clk = ~clk;
  initial begin
    do_reset();
    rc(`GIO_CTRL_OFS, 32'h0000_0010);
    cmp(io_oe, 32'h0000_0000);
    rc(`GIO_STAT_OFS, 32'h0000_0001);
    foreach (rows[i]) begin
      wr(`GIO_CTRL_OFS, rows[i].ctrl);
      wr(`GIO_OUT_OFS, rows[i].out);
      #1;
      cmp(io_oe, rows[i].oe);
      cmp(io_out, rows[i].out[15:0] & rows[i].oe);
      @(posedge clk);
      rc(`GIO_CTRL_OFS, rows[i].ctrl);
    end
    wr(`GIO_CTRL_OFS, 32'h0000_001F);
    wr(`GIO_OUT_OFS, 32'h0000_FFFF);
    fault <= 16'h0001;
    repeat (3) @(posedge clk);
    cmp(io_oe, 32'h0000_FFFC);
    rc(`GIO_ERR_OFS, 32'h0000_0003);
    fault <= 16'h0200;
    repeat (3) @(posedge clk);
    rc(`GIO_ERR_OFS, 32'h0000_0303);
    fault <= 16'h0000;
    wr(`GIO_ERR_OFS, 32'h0000_FFFF);
    rc(`GIO_ERR_OFS, 32'h0000_0000);
    cmp(io_oe, 32'h0000_FFFF);
    // settle filtered inputs low before timing them
    wr(`GIO_OUT_OFS, 32'h0000_0000);
    repeat (30) @(posedge clk);
    wr(`GIO_CTRL_OFS, 32'h0000_0010);
    ext <= 16'h0001;
    repeat (8) @(posedge clk);
    rc(`GIO_IN_OFS, 32'h0000_0000);
    repeat (20) @(posedge clk);
    rc(`GIO_IN_OFS, 32'h0000_0001);
    wr(`GIO_CTRL_OFS, 32'h0000_0000);
    ext <= 16'h0000;
    repeat (8) @(posedge clk);
    rc(`GIO_IN_OFS, 32'h0000_0000);
    // partial strobes: only byte 1 of out, control ignored without byte 0
    wstrb <= 4'h2;
    wr(`GIO_OUT_OFS, 32'h0000_A5A5);
    rc(`GIO_OUT_OFS, 32'h0000_A500);
    wstrb <= 4'hE;
    wr(`GIO_CTRL_OFS, 32'h0000_001F);
    rc(`GIO_CTRL_OFS, 32'h0000_0000);
    cmp(io_oe, 32'h0000_0000);
    wstrb <= 4'hF;
    rc(8'h20, 32'h0000_0000, `GIO_RESP_SLVERR);
    wr(`GIO_CTRL_OFS, 32'h0000_0005);
    do_reset();
    rc(`GIO_STAT_OFS, 32'h0000_0003);
    rc(`GIO_CTRL_OFS, 32'h0000_0005);
    cmp(io_oe, 32'h0000_0F0F);
    complete_run();
  end
endmodule
`default_nettype wire
